// >>> verilog/mivec_regs.svh
`ifndef MIVEC_REGS_SVH
`define MIVEC_REGS_SVH

// register byte offsets
`define MIVEC_OFF_VECTOR 4'h0
`define MIVEC_OFF_RX_RAW 4'h4
`define MIVEC_OFF_RX_MASKED 4'h8
`define MIVEC_OFF_RX_MASK_SET 4'hc
`define MIVEC_OFF_RX_MASK_CLR 5'h10
`define MIVEC_OFF_IRQ_STATUS 5'h14
`define MIVEC_OFF_IRQ_MASK 5'h18

// vector field positions
`define MIVEC_BIT_USER 31
`define MIVEC_BIT_LINK 30
`define MIVEC_BIT_HOST 17
`define MIVEC_BIT_STATS 16
`define MIVEC_POS_RX 8
`define MIVEC_POS_TX 0

// reset values
`define MIVEC_RST_WORD 32'h0000_0000
`define MIVEC_RST_CHAN 8'h00

// unmapped address read value
`define MIVEC_UNMAPPED_DATA 32'h0000_0000

`endif

// >>> verilog/mivec_pkg.sv
package mivec_pkg;
   typedef logic [7:0] mivec_chan_t;

   typedef struct packed {
      logic user;
      logic link;
      logic host;
      logic stats;
      mivec_chan_t rx;
      mivec_chan_t tx;
   } mivec_src_s;

   typedef struct packed {
      logic read;
      logic write;
      logic [4:0] address;
      logic [31:0] writedata;
   } mivec_req_s;

   typedef enum logic [1:0] {
      MIVEC_IDLE = 2'b01,
      MIVEC_RESP = 2'b10
   } mivec_state_e;
endpackage

// >>> verilog/mivec_top.sv
`timescale 1ns/10ps
`include "mivec_regs.svh"
// Behaviour
// RULE1: vector bit 31 shows the user management event pending.
// RULE2: vector bit 30 shows the link change pending.
// RULE3: reserved bits read zero; writes to them do nothing.
// RULE4: vector bit 17 shows host error pending.
// RULE5: vector bit 16 shows statistics event pending.
// RULE6: vector bits 15..8 carry receive channels 0..7, channel 0 at bit 8.
// RULE7: vector bits 7..0 carry transmit channels 0..7, channel 0 at bit 0.
// RULE8: one vector read reveals every current pending source; receive channels show there only while enabled.
// RULE9: raw receive status bit n shows channel n pending, mask ignored.
// RULE10: masked receive status bit n is pending gated by channel enable.
// RULE11: receive status bits are read-only and read zero after reset.
// RULE12: writing one to mask set enables a channel; zero leaves it.
// RULE13: writes to the three status registers change nothing.
// RULE14: vector receive bits equal masked receive status in same cycle.
module mivec_top (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // avalon-mm slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // interrupt sources, levels from other blocks
   input wire mivec_pkg::mivec_src_s src_pending,
   // interrupt output
   output logic irq
);
   import mivec_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   logic rst_meta_q;
   logic rst_n_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sources registered once; all status words read from these copies
   mivec_src_s src_q;
   mivec_chan_t rx_en_q;
   mivec_chan_t rx_masked;
   logic [31:0] vector;

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         src_q <= '0;
      end else begin
         src_q <= src_pending;
      end
   end

   // RULE10: mask gating
   assign rx_masked = src_q.rx & rx_en_q;

   always_comb begin
      // RULE3: reserved vector bits zero
      vector = `MIVEC_RST_WORD;
      // RULE1: user event bit
      vector[`MIVEC_BIT_USER] = src_q.user;
      // RULE2: link change bit
      vector[`MIVEC_BIT_LINK] = src_q.link;
      // RULE4: host error bit
      vector[`MIVEC_BIT_HOST] = src_q.host;
      // RULE5: statistics bit
      vector[`MIVEC_BIT_STATS] = src_q.stats;
      // RULE6: receive channels, RULE14: masked copy
      vector[`MIVEC_POS_RX +: 8] = rx_masked;
      // RULE7: transmit channels
      vector[`MIVEC_POS_TX +: 8] = src_q.tx;
   end

   ////////////////////////////////////////////////////////////////////////
   // bus handshake: one wait cycle, answer on the next edge
   mivec_req_s req;
   mivec_state_e state_q;
   logic take;

   assign req = '{read: avs_read, write: avs_write, address: avs_address,
                  writedata: avs_writedata};
   assign take = (state_q == MIVEC_IDLE) && (req.read || req.write);

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q <= MIVEC_IDLE;
      end else begin
         unique case (state_q)
            MIVEC_IDLE: begin
               if (take) begin
                  state_q <= MIVEC_RESP;
               end
            end
            MIVEC_RESP: begin
               state_q <= MIVEC_IDLE;
            end
         endcase
      end
   end

   // waitrequest high unless the answer is ready this cycle
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !take;
      end
   end

   function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
      hit = (a == off);
   endfunction

   logic wr_fire;
   logic rd_fire;
   assign wr_fire = take && req.write;
   assign rd_fire = take && req.read;

   ////////////////////////////////////////////////////////////////////////
   // receive channel enables
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rx_en_q <= `MIVEC_RST_CHAN;
      end else if (wr_fire && hit(req.address, 5'(`MIVEC_OFF_RX_MASK_SET))) begin
         // RULE12: write one sets enable
         rx_en_q <= rx_en_q | req.writedata[7:0];
      end else if (wr_fire && hit(req.address, 5'(`MIVEC_OFF_RX_MASK_CLR))) begin
         rx_en_q <= rx_en_q & ~req.writedata[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sticky event bits: rising edge of any vector bit
   logic [31:0] vec_prev_q;
   logic [31:0] evt_q;
   logic [31:0] evt_mask_q;
   logic [31:0] rise;
   logic evt_rd;

   assign rise = vector & ~vec_prev_q;
   assign evt_rd = rd_fire && hit(req.address, `MIVEC_OFF_IRQ_STATUS);

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         vec_prev_q <= `MIVEC_RST_WORD;
      end else begin
         vec_prev_q <= vector;
      end
   end

   // read clears, but a rise in the same cycle survives
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         evt_q <= `MIVEC_RST_WORD;
      end else if (evt_rd) begin
         evt_q <= rise;
      end else begin
         evt_q <= evt_q | rise;
      end
   end

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         evt_mask_q <= `MIVEC_RST_WORD;
      end else if (wr_fire && hit(req.address, `MIVEC_OFF_IRQ_MASK)) begin
         evt_mask_q <= req.writedata & 32'hc003_ffff;
      end
   end

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         irq <= 1'b0;
      end else begin
         irq <= |(evt_q & evt_mask_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read mux; status writes fall through with no effect
   logic [31:0] rdata;

   always_comb begin
      rdata = `MIVEC_UNMAPPED_DATA;
      unique case (req.address)
         // RULE8: whole vector in one word
         5'(`MIVEC_OFF_VECTOR): rdata = vector;
         // RULE9: raw receive, RULE11: read-only
         5'(`MIVEC_OFF_RX_RAW): rdata = {24'h00_0000, src_q.rx};
         // RULE10: masked receive
         5'(`MIVEC_OFF_RX_MASKED): rdata = {24'h00_0000, rx_masked};
         5'(`MIVEC_OFF_RX_MASK_SET): rdata = {24'h00_0000, rx_en_q};
         5'(`MIVEC_OFF_RX_MASK_CLR): rdata = {24'h00_0000, rx_en_q};
         `MIVEC_OFF_IRQ_STATUS: rdata = evt_q;
         `MIVEC_OFF_IRQ_MASK: rdata = evt_mask_q;
         default: rdata = `MIVEC_UNMAPPED_DATA;
      endcase
   end

   // RULE13: status offsets have no write path at all
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         avs_readdata <= `MIVEC_RST_WORD;
      end else if (rd_fire) begin
         avs_readdata <= rdata;
      end
   end
endmodule

// >>> tb/mivec_top_monitor.sv
`timescale 1ns/10ps
module mivec_top_monitor (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // watched ports
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire mivec_pkg::mivec_src_s src_pending,
   input wire logic irq
);
   import mivec_pkg::*;
   mivec_src_s s1_q, s2_q;
   logic rv, st, vs;
   // fields other than reserved vector bits judged only when sources sat still across the sampling edge
   always_ff @(posedge clk) begin
      s1_q <= src_pending;
      s2_q <= s1_q;
   end
   assign rv = !avs_waitrequest && avs_read;
   assign st = rv && src_pending == s1_q && s1_q == s2_q;
   assign vs = st && avs_address == 5'h00;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   take_ans_a: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
      else $error("request not answered");
   wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("answer too long");
   user_bit_a: assert property (vs |-> avs_readdata[31] == src_pending.user)
      else $error("bad user bit");
   link_bit_a: assert property (vs |-> avs_readdata[30] == src_pending.link)
      else $error("bad link bit");
   vec_rsvd_a: assert property (rv && avs_address == 5'h00 |-> avs_readdata[29:18] == 12'h000)
      else $error("reserved bits set");
   tx_field_a: assert property (vs |-> avs_readdata[7:0] == src_pending.tx)
      else $error("bad tx field");
   raw_rx_a: assert property (st && avs_address == 5'h04 |-> avs_readdata == {24'h0, src_pending.rx})
      else $error("bad raw rx");
   masked_rx_a: assert property (st && avs_address == 5'h08 |-> (avs_readdata[7:0] & ~src_pending.rx) == 8'h00)
      else $error("masked rx not pending");
   cover property (vs);
   cover property ($rose(irq));
   cover property (avs_write && !avs_waitrequest);
endmodule
bind mivec_top mivec_top_monitor i_mon (.clk, .arst_n, .avs_address, .avs_read, .avs_write,
   .avs_readdata, .avs_waitrequest, .src_pending, .irq);

// >>> tb/test_mac_interrupt_status_vector.sv
`timescale 1ns/10ps
module test_mac_interrupt_status_vector;
   import mivec_pkg::*;
   logic clk = 0, arst_n = 0, avs_read = 0, avs_write = 0, avs_waitrequest, irq;
   logic [4:0] avs_address = 5'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, seed = 32'h0206;
   logic [7:0] en = 8'h00;
   mivec_src_s src_pending = '0;
   int fails = 0, comparisons = 0, cyc = 0;
   mivec_top i_dut (.clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .src_pending, .irq);
   initial forever #5 clk = ~clk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] vec(input mivec_src_s s, input logic [7:0] e);
      return {s.user, s.link, 12'h000, s.host, s.stats, s.rx & e, s.tx};
   endfunction
   task automatic final_report();
      $display("fails %0d comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // pre-edge values are read right after the edge wakes us
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !w;
      avs_write <= w;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc > 20000) begin
         fails++;
         final_report();
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk);
      for (int a = 0; a < 3; a++) begin
         bus(0, 5'(a * 4), 32'h0);
         chk(rd, 32'h0);
      end
      chk({31'h0, irq}, 32'h0);
      for (int i = 0; i < 24; i++) begin
         seed = lfsr(seed);
         src_pending <= mivec_src_s'(seed[27:0]);
         // reserved upper ones must not stick
         bus(1, 5'h0c, {24'hffffff, seed[31:24]});
         en = en | seed[31:24];
         bus(1, 5'h10, {24'hffffff, seed[11:4]});
         en = en & ~seed[11:4];
         bus(1, 5'h00, 32'hffff_ffff);
         bus(1, 5'h04, 32'hffff_ffff);
         bus(1, 5'h08, 32'hffff_ffff);
         bus(0, 5'h00, 32'h0);
         chk(rd, vec(src_pending, en));
         bus(0, 5'h04, 32'h0);
         chk(rd, {24'h0, src_pending.rx});
         bus(0, 5'h08, 32'h0);
         chk(rd, {24'h0, src_pending.rx & en});
         bus(0, 5'h0c, 32'h0);
         chk(rd, {24'h0, en});
      end
      bus(0, 5'h1c, 32'h0);
      chk(rd, 32'h0);
      src_pending <= '0;
      bus(1, 5'h18, 32'h0);
      bus(0, 5'h14, 32'h0);
      bus(1, 5'h18, 32'h8000_0000);
      src_pending.user <= 1'b1;
      repeat (4) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      bus(0, 5'h14, 32'h0);
      chk(rd & 32'h8000_0000, 32'h8000_0000);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      src_pending.link <= 1'b1;
      repeat (4) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      final_report();
   end
endmodule
